// ### hdl/sac_pkg.sv
package sac_pkg;

  // Register byte addresses on the word-wide bus
  localparam logic [4:0] SAC_ADDR_CTRL1   = 5'h00;
  localparam logic [4:0] SAC_ADDR_CTRL2   = 5'h04;
  localparam logic [4:0] SAC_ADDR_RESULT  = 5'h08;
  localparam logic [4:0] SAC_ADDR_COMPARE = 5'h0C;
  localparam logic [4:0] SAC_ADDR_CONFIG  = 5'h10;
  localparam logic [4:0] SAC_ADDR_PIN1    = 5'h14;
  localparam logic [4:0] SAC_ADDR_PIN2    = 5'h18;

  // Control 1 fields
  localparam int SAC_C1_COMPLETE = 7;
  localparam int SAC_C1_INT_EN   = 6;
  localparam int SAC_C1_CONT     = 5;
  localparam int SAC_C1_CH_LSB   = 0;

  // Control 2 fields
  localparam int SAC_C2_ACTIVE   = 7;
  localparam int SAC_C2_HW_TRIG  = 6;
  localparam int SAC_C2_CMP_EN   = 5;
  localparam int SAC_C2_CMP_GTE  = 4;

  // Configuration fields
  localparam int SAC_CFG_DIV_LSB = 5;
  localparam int SAC_CFG_MODE_LSB = 2;
  localparam int SAC_CFG_SRC_LSB = 0;

  // Reset values
  localparam logic [7:0] SAC_CTRL1_RST  = 8'h1F;
  localparam logic [7:0] SAC_CTRL2_RST  = 8'h00;
  localparam logic [7:0] SAC_CONFIG_RST = 8'h00;
  localparam logic [7:0] SAC_PIN_RST    = 8'h00;

  // Channel codes
  localparam logic [4:0] SAC_CH_LOW_LAST  = 5'h0F;
  localparam logic [4:0] SAC_CH_HIGH_LAST = 5'h1B;
  localparam logic [4:0] SAC_CH_RSV_FIRST = 5'h16;
  localparam logic [4:0] SAC_CH_RSV_LAST  = 5'h19;
  localparam logic [4:0] SAC_CH_TEMP      = 5'h1A;
  localparam logic [4:0] SAC_CH_BANDGAP   = 5'h1B;
  localparam logic [4:0] SAC_CH_RSV_SOLO  = 5'h1C;
  localparam logic [4:0] SAC_CH_OFF       = 5'h1F;

  // Conversion resolution
  localparam int SAC_RES_BITS = 12;

  // Conversion clock sources
  typedef enum logic [1:0] {
    SAC_SRC_BUS      = 2'b00,
    SAC_SRC_BUS_DIV2 = 2'b01,
    SAC_SRC_ALT      = 2'b10,
    SAC_SRC_LOCAL    = 2'b11
  } sac_src_type;

  // Result widths
  typedef enum logic [1:0] {
    SAC_MODE_8   = 2'b00,
    SAC_MODE_12  = 2'b01,
    SAC_MODE_10  = 2'b10,
    SAC_MODE_RSV = 2'b11
  } sac_mode_type;

  // Engine states
  typedef enum logic [1:0] {
    SAC_ST_IDLE    = 2'b00,
    SAC_ST_SAMPLE  = 2'b01,
    SAC_ST_CONVERT = 2'b10
  } sac_state_type;

endpackage

// ### hdl/sac_conv_if.sv
interface sac_conv_if;
  import sac_pkg::*;

  logic                    start;
  logic                    abort;
  logic                    tick;
  logic                    busy;
  logic                    done;
  logic [SAC_RES_BITS-1:0] result;

  modport ctl (output start, output abort, output tick, input busy, input done, input result);
  modport eng (input start, input abort, input tick, output busy, output done, output result);
endinterface

// ### hdl/sac_sar_engine.sv
module sac_sar_engine
  import sac_pkg::*;
#(
  parameter int SAMPLE_TICKS = 4
) (
  // Clock and reset
  input  wire logic                    clk_sys_i,
  input  wire logic                    rst_i,
  // Control side
  sac_conv_if.eng                      conv,
  // Analog comparator and DAC trial word
  input  wire logic                    sar_cmp_i,
  output logic      [SAC_RES_BITS-1:0] sar_dac_o
);

  sac_state_type           state_r;
  logic [SAC_RES_BITS-1:0] trial_r;
  logic [SAC_RES_BITS-1:0] mask_r;
  logic [SAC_RES_BITS-1:0] result_r;
  logic [7:0]              samp_r;
  logic                    done_r;
  logic [SAC_RES_BITS-1:0] kept;

  // Keep the trial bit only when input is at or above it
  assign kept = sar_cmp_i ? trial_r : (trial_r & ~mask_r);

  assign conv.busy   = (state_r != SAC_ST_IDLE);
  assign conv.done   = done_r;
  assign conv.result = result_r;
  assign sar_dac_o   = trial_r;

  ////////////////////////////////////////////////////////////////////////
  // Sequencer; start wins over abort so a write restarts cleanly
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      state_r  <= SAC_ST_IDLE;
      trial_r  <= '0;
      mask_r   <= '0;
      result_r <= '0;
      samp_r   <= 8'h00;
      done_r   <= 1'b0;
    end else begin
      done_r <= 1'b0;
      if (conv.start) begin
        state_r <= SAC_ST_SAMPLE;
        samp_r  <= 8'h00;
        trial_r <= '0;
      end else if (conv.abort) begin
        state_r <= SAC_ST_IDLE;
        trial_r <= '0;
      end else if (conv.tick) begin
        unique case (state_r)
          SAC_ST_IDLE: begin
            state_r <= SAC_ST_IDLE;
          end
          SAC_ST_SAMPLE: begin
            if (samp_r == 8'(SAMPLE_TICKS - 1)) begin
              state_r <= SAC_ST_CONVERT;
              mask_r  <= {1'b1, {(SAC_RES_BITS-1){1'b0}}};
              trial_r <= {1'b1, {(SAC_RES_BITS-1){1'b0}}};
            end else begin
              samp_r <= samp_r + 8'h01;
            end
          end
          SAC_ST_CONVERT: begin
            if (mask_r[0]) begin
              result_r <= kept;
              done_r   <= 1'b1;
              state_r  <= SAC_ST_IDLE;
              trial_r  <= '0;
            end else begin
              mask_r  <= mask_r >> 1;
              trial_r <= kept | (mask_r >> 1);
            end
          end
          default: begin
            state_r <= SAC_ST_IDLE;
          end
        endcase
      end
    end
  end

endmodule

// ### hdl/sac_converter_ctrl.sv
// Contract
// - Decode 5-bit channel; low sixteen gated by pin enables, high twelve ungated.
// - Reserved channel codes leave the input isolated; result undefined.
// - Channel 11010 routes the temperature sensor to the converter input.
// - Conversion clock source: bus, bus halved, local async, alternate input.
// - Alternate clock input comes from the external reference clock.
// - Conversion clock is the selected source divided by the divide field.
// - Alternate clock keeps running in wait mode.
// - With hardware trigger selected, counter match starts a conversion.
// - Match trigger is produced whatever the counter interrupt setting.
// - Match trigger is delivered in run, wait and stop3.
// - Exactly two analog pin enable registers cover sixteen pins.
// - Linear successive approximation with twelve-bit resolution.
// - Result right-justified unsigned in twelve, ten or eight bits.
// - Single and continuous modes; single returns to idle itself.
// - Conversion complete flag plus an enableable interrupt request.
// - Optional automatic compare, less-than or greater-or-equal, flags completion.
// - Channel all ones powers the converter off and isolates the input.
// - Writing control 1 aborts; restarts unless channel written all ones or hardware trigger selected.
module sac_converter_ctrl
  import sac_pkg::*;
#(
  parameter int CNT_WIDTH    = 16,
  parameter int LOCAL_DIV    = 4,
  parameter int SAMPLE_TICKS = 4
) (
  // Clock and reset
  input  wire logic                    clk_sys_i,
  input  wire logic                    rst_i,
  // Avalon-MM slave
  input  wire logic [4:0]              avs_address_i,
  input  wire logic                    avs_read_i,
  input  wire logic                    avs_write_i,
  input  wire logic [31:0]             avs_writedata_i,
  input  wire logic [3:0]              avs_byteenable_i,
  output logic      [31:0]             avs_readdata_o,
  output logic                         avs_waitrequest_o,
  // Periodic counter (same clock)
  input  wire logic [CNT_WIDTH-1:0]    periodic_counter_value_i,
  input  wire logic [CNT_WIDTH-1:0]    periodic_counter_modulo_i,
  // Alternate clock pin and power modes
  input  wire logic                    ext_reference_clock_i,
  input  wire logic                    wait_mode_i,
  input  wire logic                    stop3_mode_i,
  // Analog front end
  input  wire logic                    sar_cmp_i,
  output logic      [SAC_RES_BITS-1:0] sar_dac_o,
  output logic      [4:0]              mux_select_o,
  output logic                         mux_enable_o,
  output logic                         temp_sensor_route_o,
  output logic                         bandgap_route_o,
  output logic                         converter_power_o,
  output logic      [15:0]             pin_analog_enable_o,
  // Interrupt request
  output logic                         irq_o
);

  ////////////////////////////////////////////////////////////////////////
  // Helpers

  // Codes that do not reach a real input
  function automatic logic is_reserved(input logic [4:0] ch);
    is_reserved = ((ch >= SAC_CH_RSV_FIRST) && (ch <= SAC_CH_RSV_LAST)) || (ch == SAC_CH_RSV_SOLO);
  endfunction

  // Right-justify the raw result into the chosen width
  function automatic logic [SAC_RES_BITS-1:0] fmt(input logic [SAC_RES_BITS-1:0] raw,
                                                   input logic [1:0] mode);
    unique case (mode)
      SAC_MODE_8:  fmt = {4'h0, raw[11:4]};
      SAC_MODE_10: fmt = {2'h0, raw[11:2]};
      default:     fmt = raw;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Registers

  logic [7:0]              ctrl1_r;
  logic [7:0]              ctrl2_r;
  logic [7:0]              config_r;
  logic [7:0]              pin1_r;
  logic [7:0]              pin2_r;
  logic [15:0]             compare_r;
  logic [SAC_RES_BITS-1:0] result_r;
  logic                    complete_r;
  logic                    ack_r;
  logic [31:0]             rdata_r;

  sac_conv_if conv ();

  // Field views
  wire logic [4:0] channel_select     = ctrl1_r[SAC_C1_CH_LSB +: 5];
  wire logic       cont_en            = ctrl1_r[SAC_C1_CONT];
  wire logic       int_en             = ctrl1_r[SAC_C1_INT_EN];
  wire logic       hw_trigger_select  = ctrl2_r[SAC_C2_HW_TRIG];
  wire logic       cmp_en             = ctrl2_r[SAC_C2_CMP_EN];
  wire logic       cmp_gte            = ctrl2_r[SAC_C2_CMP_GTE];
  wire logic [1:0] clk_src            = config_r[SAC_CFG_SRC_LSB +: 2];
  wire logic [1:0] res_mode           = config_r[SAC_CFG_MODE_LSB +: 2];
  wire logic [1:0] clock_divide_select = config_r[SAC_CFG_DIV_LSB +: 2];
  wire logic [15:0] pin_en            = {pin2_r, pin1_r};

  // Bus decode; accesses complete on the cycle waitrequest drops
  wire logic bus_req  = avs_read_i | avs_write_i;
  wire logic wr_acc   = avs_write_i & ack_r;
  wire logic rd_acc   = avs_read_i & ack_r;
  wire logic lane0    = avs_byteenable_i[0];
  wire logic lane1    = avs_byteenable_i[1];
  wire logic wr_c1    = wr_acc & lane0 & (avs_address_i == SAC_ADDR_CTRL1);
  wire logic wr_c2    = wr_acc & lane0 & (avs_address_i == SAC_ADDR_CTRL2);
  wire logic wr_cfg   = wr_acc & lane0 & (avs_address_i == SAC_ADDR_CONFIG);
  wire logic wr_p1    = wr_acc & lane0 & (avs_address_i == SAC_ADDR_PIN1);
  wire logic wr_p2    = wr_acc & lane0 & (avs_address_i == SAC_ADDR_PIN2);
  wire logic wr_cmp   = wr_acc & (avs_address_i == SAC_ADDR_COMPARE);
  wire logic rd_res   = rd_acc & (avs_address_i == SAC_ADDR_RESULT);
  wire logic [4:0] wr_ch = avs_writedata_i[SAC_C1_CH_LSB +: 5];

  assign avs_waitrequest_o = bus_req & ~ack_r;
  assign avs_readdata_o    = rdata_r;

  // Read mux; unmapped addresses read as zero
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (avs_address_i)
      SAC_ADDR_CTRL1:   rd_mux = {24'h0, complete_r, ctrl1_r[6:0]};
      SAC_ADDR_CTRL2:   rd_mux = {24'h0, conv.busy, ctrl2_r[6:0]};
      SAC_ADDR_RESULT:  rd_mux = {20'h0, result_r};
      SAC_ADDR_COMPARE: rd_mux = {16'h0, compare_r};
      SAC_ADDR_CONFIG:  rd_mux = {24'h0, config_r};
      SAC_ADDR_PIN1:    rd_mux = {24'h0, pin1_r};
      SAC_ADDR_PIN2:    rd_mux = {24'h0, pin2_r};
      default:          rd_mux = 32'h0000_0000;
    endcase
  end

  // One wait state per access, then a one-cycle answer
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      ack_r   <= 1'b0;
      rdata_r <= 32'h0000_0000;
    end else begin
      ack_r <= bus_req & ~ack_r;
      if (avs_read_i & ~ack_r) begin
        rdata_r <= rd_mux;
      end
    end
  end

  // Software-written registers
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl1_r   <= SAC_CTRL1_RST;
      ctrl2_r   <= SAC_CTRL2_RST;
      config_r  <= SAC_CONFIG_RST;
      pin1_r    <= SAC_PIN_RST;
      pin2_r    <= SAC_PIN_RST;
      compare_r <= 16'h0000;
    end else begin
      if (wr_c1) ctrl1_r <= {1'b0, avs_writedata_i[6:0]};
      if (wr_c2) ctrl2_r <= {1'b0, avs_writedata_i[6:4], 4'h0};
      if (wr_cfg) config_r <= avs_writedata_i[7:0];
      if (wr_p1) pin1_r <= avs_writedata_i[7:0];
      if (wr_p2) pin2_r <= avs_writedata_i[7:0];
      if (wr_cmp & lane0) compare_r[7:0] <= avs_writedata_i[7:0];
      if (wr_cmp & lane1) compare_r[15:8] <= avs_writedata_i[15:8];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Conversion clock

  // Pin sampled through three flops; edge counts once two and three agree
  logic [2:0] alt_sync_r;
  logic       alt_lvl_r;
  logic       half_r;
  logic [7:0] local_cnt_r;
  logic [2:0] div_cnt_r;
  logic       src_tick;
  logic       alt_rise;
  logic       local_tick;
  logic [2:0] div_last;

  // alternate source is the external reference clock pin
  assign alt_rise   = (alt_sync_r[1] == alt_sync_r[2]) & alt_sync_r[2] & ~alt_lvl_r;
  assign local_tick = (local_cnt_r == 8'(LOCAL_DIV - 1));
  assign div_last   = 3'((4 << clock_divide_select) >> 2) - 3'h1;

  // four clock sources; bus sources halt in stop3
  // alternate source gated only in stop3, so wait mode keeps it
  always_comb begin
    src_tick = 1'b0;
    unique case (clk_src)
      SAC_SRC_BUS:      src_tick = ~stop3_mode_i;
      SAC_SRC_BUS_DIV2: src_tick = ~stop3_mode_i & half_r;
      SAC_SRC_ALT:      src_tick = ~stop3_mode_i & alt_rise;
      SAC_SRC_LOCAL:    src_tick = local_tick;
      default:          src_tick = 1'b0;
    endcase
  end

  // divide selected source by 1, 2, 4 or 8
  assign conv.tick = src_tick & (div_cnt_r == div_last);

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      alt_sync_r  <= 3'h0;
      alt_lvl_r   <= 1'b0;
      half_r      <= 1'b0;
      local_cnt_r <= 8'h00;
      div_cnt_r   <= 3'h0;
    end else begin
      alt_sync_r <= {alt_sync_r[1:0], ext_reference_clock_i};
      if (alt_sync_r[1] == alt_sync_r[2]) alt_lvl_r <= alt_sync_r[2];
      half_r      <= ~half_r;
      local_cnt_r <= local_tick ? 8'h00 : local_cnt_r + 8'h01;
      if (src_tick) div_cnt_r <= (div_cnt_r == div_last) ? 3'h0 : div_cnt_r + 3'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Hardware trigger

  logic match_d_r;
  logic trig_pend_r;
  logic match_now;
  logic hw_start;

  // match ignores the counter's own interrupt enable
  // no power-mode gating on the match itself
  assign match_now = (periodic_counter_value_i == periodic_counter_modulo_i);

  // match starts a conversion when hardware trigger selected
  assign hw_start = hw_trigger_select & trig_pend_r & conv.tick & ~conv.busy & (channel_select != SAC_CH_OFF);

  // rising edge only; held until a conversion clock tick
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      match_d_r   <= 1'b0;
      trig_pend_r <= 1'b0;
    end else begin
      match_d_r <= match_now;
      if (match_now & ~match_d_r & hw_trigger_select) trig_pend_r <= 1'b1;
      else if (conv.tick | ~hw_trigger_select) trig_pend_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Start, abort and completion

  logic [SAC_RES_BITS-1:0] fmt_res;
  logic                    cmp_true;
  logic                    done_ok;
  logic                    sw_start;
  logic                    cont_start;

  // control 1 write aborts, restarts unless channel off or hardware trigger selected
  assign sw_start   = wr_c1 & (wr_ch != SAC_CH_OFF) & ~hw_trigger_select;
  // continuous restarts on done; single just stops
  assign cont_start = conv.done & cont_en & (channel_select != SAC_CH_OFF) & ~wr_c1;
  assign conv.start = sw_start | cont_start | hw_start;
  assign conv.abort = wr_c1;

  assign fmt_res = fmt(conv.result, res_mode);
  // less-than or greater-or-equal against compare value
  assign cmp_true = cmp_gte ? ({4'h0, fmt_res} >= compare_r) : ({4'h0, fmt_res} < compare_r);
  assign done_ok  = conv.done & (~cmp_en | cmp_true);

  // complete flag; a new completion beats a clearing access
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      complete_r <= 1'b0;
      result_r   <= '0;
    end else begin
      complete_r <= done_ok | (complete_r & ~(wr_c1 | rd_res));
      if (done_ok) result_r <= fmt_res;
    end
  end

  assign irq_o = complete_r & int_en;

  ////////////////////////////////////////////////////////////////////////
  // Input selection

  // low group gated by its pin enable bit
  // reserved codes keep the input isolated
  // all ones powers down and isolates
  assign mux_enable_o = (channel_select <= SAC_CH_LOW_LAST) ? pin_en[channel_select[3:0]]
                      : ~is_reserved(channel_select) & (channel_select != SAC_CH_OFF);
  assign mux_select_o        = channel_select;
  assign converter_power_o   = (channel_select != SAC_CH_OFF);
  assign temp_sensor_route_o = (channel_select == SAC_CH_TEMP);
  // bandgap route, buffer enabled by software elsewhere
  assign bandgap_route_o     = (channel_select == SAC_CH_BANDGAP);
  assign pin_analog_enable_o = pin_en;

  ////////////////////////////////////////////////////////////////////////
  // Engine

  sac_sar_engine #(
    .SAMPLE_TICKS (SAMPLE_TICKS)
  ) u_engine (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .conv      (conv),
    .sar_cmp_i (sar_cmp_i),
    .sar_dac_o (sar_dac_o)
  );

endmodule

// ### testbench/sac_converter_ctrl_props.sv
module sac_converter_ctrl_props
  import sac_pkg::*;
(
  // Clock and reset
  input wire logic        clk_sys_i,
  input wire logic        rst_i,
  // Register bus
  input wire logic [4:0]  avs_address_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0]  avs_byteenable_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic        avs_waitrequest_o,
  // Front end and request
  input wire logic [4:0]  mux_select_o,
  input wire logic        mux_enable_o,
  input wire logic        temp_sensor_route_o,
  input wire logic        bandgap_route_o,
  input wire logic        converter_power_o,
  input wire logic [15:0] pin_analog_enable_o,
  input wire logic        irq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);

  // Accepted lane-0 write and reserved decode
  wire logic wr_ok = avs_write_i & ~avs_waitrequest_o & avs_byteenable_i[0];
  wire logic rsv_ch = mux_select_o inside {[SAC_CH_RSV_FIRST:SAC_CH_RSV_LAST], SAC_CH_RSV_SOLO};

  //////////////////////////////////////////
  // Exactly one wait state, none when idle
  a_one_wait: assert property ((avs_read_i | avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("waitrequest held too long");
  a_idle_no_wait: assert property (!(avs_read_i | avs_write_i) |-> !avs_waitrequest_o)
    else $error("waitrequest without request");
  a_ctrl1_chan: assert property (wr_ok && avs_address_i == SAC_ADDR_CTRL1 |=>
    mux_select_o == $past(avs_writedata_i[4:0])) else $error("channel not taken");
  a_pin_low: assert property (wr_ok && avs_address_i == SAC_ADDR_PIN1 |=>
    pin_analog_enable_o[7:0] == $past(avs_writedata_i[7:0])) else $error("pin enable low wrong");
  a_pin_high: assert property (wr_ok && avs_address_i == SAC_ADDR_PIN2 |=>
    pin_analog_enable_o[15:8] == $past(avs_writedata_i[7:0])) else $error("pin enable high wrong");
  a_no_third: assert property (avs_read_i && !avs_waitrequest_o && avs_address_i == 5'h1C |->
    avs_readdata_o == 32'h0000_0000) else $error("unmapped read not zero");
  a_low_gated: assert property (mux_select_o <= SAC_CH_LOW_LAST |->
    mux_enable_o == pin_analog_enable_o[mux_select_o[3:0]]) else $error("low channel gate wrong");
  a_rsv_isolated: assert property (rsv_ch |-> !mux_enable_o)
    else $error("reserved channel connected");
  a_temp_route: assert property (temp_sensor_route_o == (mux_select_o == SAC_CH_TEMP))
    else $error("temperature route wrong");
  a_bandgap_route: assert property (bandgap_route_o == (mux_select_o == SAC_CH_BANDGAP))
    else $error("bandgap route wrong");
  a_off_isolate: assert property (mux_select_o == SAC_CH_OFF |-> !converter_power_o && !mux_enable_o)
    else $error("off code leaves converter on");

  // Main scenarios reached
  cover property (wr_ok && avs_address_i == SAC_ADDR_CTRL1);
  cover property ($rose(irq_o));
  cover property (mux_select_o == SAC_CH_TEMP && mux_enable_o);
endmodule

bind sac_converter_ctrl sac_converter_ctrl_props i_props (
  .clk_sys_i, .rst_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_byteenable_i,
  .avs_readdata_o, .avs_waitrequest_o, .mux_select_o, .mux_enable_o, .temp_sensor_route_o,
  .bandgap_route_o, .converter_power_o, .pin_analog_enable_o, .irq_o);

// ### testbench/sac_far_model.sv
module sac_far_model
#(
  parameter logic [15:0] MODULO = 16'h0040
) (
  // Clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        rst_i,
  // Bench controls
  input  wire logic        run_i,
  input  wire logic [11:0] analog_i,
  // Toward the converter
  input  wire logic [11:0] dac_i,
  output logic             cmp_o,
  output logic      [15:0] value_o,
  output logic      [15:0] modulo_o,
  output logic             ref_clk_o
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [1:0] ref_div_r;

  // Match in any power mode; slow free reference clock
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      value_o   <= 16'h0000;
      ref_div_r <= 2'h0;
      ref_clk_o <= 1'b0;
    end else begin
      if (run_i) value_o <= (value_o == MODULO) ? 16'h0000 : value_o + 16'h0001;
      ref_div_r <= (ref_div_r == 2'h2) ? 2'h0 : ref_div_r + 2'h1;
      ref_clk_o <= (ref_div_r == 2'h2) ? ~ref_clk_o : ref_clk_o;
    end
  end
  assign modulo_o = MODULO;

  // Ideal comparator: the search lands on the input exactly
  assign cmp_o = (analog_i >= dac_i);
endmodule

// ### testbench/testbench.sv
module testbench
  import sac_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // Design-facing nets
  logic        clk_sys_i, rst_i, avs_read_i, avs_write_i, avs_waitrequest_o, irq_o, run;
  logic        wait_mode_i, stop3_mode_i, sar_cmp_i, ext_reference_clock_i, mux_enable_o;
  logic        temp_sensor_route_o, bandgap_route_o, converter_power_o;
  logic [4:0]  avs_address_i, mux_select_o;
  logic [11:0] sar_dac_o, analog;
  logic [15:0] periodic_counter_value_i, periodic_counter_modulo_i, pin_analog_enable_o;
  logic [31:0] avs_writedata_i, avs_readdata_o, q;
  int          err_count, checks_done;
  logic [4:0]  ra [6] = '{SAC_ADDR_CTRL1, SAC_ADDR_CTRL2, SAC_ADDR_CONFIG, SAC_ADDR_PIN1, SAC_ADDR_PIN2, 5'h1C};
  logic [7:0]  rv [6] = '{SAC_CTRL1_RST, SAC_CTRL2_RST, SAC_CONFIG_RST, SAC_PIN_RST, SAC_PIN_RST, 8'h00};

  sac_converter_ctrl i_dut (
    .clk_sys_i, .rst_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
    .avs_byteenable_i(4'hF), .avs_readdata_o, .avs_waitrequest_o, .periodic_counter_value_i,
    .periodic_counter_modulo_i, .ext_reference_clock_i, .wait_mode_i, .stop3_mode_i, .sar_cmp_i,
    .sar_dac_o, .mux_select_o, .mux_enable_o, .temp_sensor_route_o, .bandgap_route_o,
    .converter_power_o, .pin_analog_enable_o, .irq_o);

  sac_far_model i_far (
    .clk_sys_i, .rst_i, .run_i(run), .analog_i(analog), .dac_i(sar_dac_o), .cmp_o(sar_cmp_i),
    .value_o(periodic_counter_value_i), .modulo_o(periodic_counter_modulo_i),
    .ref_clk_o(ext_reference_clock_i));

  //////////////////////////////////////////
  // Expected formatting and input gating
  function automatic logic [31:0] fmt(input logic [11:0] v, input logic [1:0] m);
    return (m == SAC_MODE_8) ? 32'(v[11:4]) : (m == SAC_MODE_10) ? 32'(v[11:2]) : 32'(v);
  endfunction
  function automatic logic exp_en(input logic [4:0] c, input logic [15:0] p);
    if (c <= SAC_CH_LOW_LAST) return p[c[3:0]];
    return !(c inside {[SAC_CH_RSV_FIRST:SAC_CH_RSV_LAST], SAC_CH_RSV_SOLO, SAC_CH_OFF});
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    if (err_count == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Held until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    {avs_address_i, avs_writedata_i, avs_write_i, avs_read_i} <= {a, d, wr, ~wr};
    do begin
      @(posedge clk_sys_i);
      n++;
      if (n > 20) begin err_count++; end_sim(); end
    end while (avs_waitrequest_o !== 1'b0);
    q = avs_readdata_o;
    {avs_write_i, avs_read_i} <= 2'b00;
    @(negedge clk_sys_i);
  endtask
  task automatic idle(input int lim, output int n);
    for (n = 0; n < lim; n++) begin
      bus(1'b0, SAC_ADDR_CTRL2, 32'h0);
      if (q[SAC_C2_ACTIVE] === 1'b0) break;
    end
    if (n == lim) begin err_count++; end_sim(); end
  endtask
  task automatic wait_irq(input int lim);
    for (int n = 0; irq_o !== 1'b1; n++) begin
      if (n > lim) begin err_count++; end_sim(); end
      @(negedge clk_sys_i);
    end
  endtask

  // Free-running system clock
  initial begin
    clk_sys_i = 1'b0;
    forever #2 clk_sys_i = ~clk_sys_i;
  end

  //////////////////////////////////////////
  initial begin
    logic [31:0] r, x, cmp, pins;
    logic [1:0]  md;
    logic        f;
    int          n, tm [3];
    {avs_address_i, avs_read_i, avs_write_i, avs_writedata_i} = '0;
    {wait_mode_i, stop3_mode_i, run, analog} = '0;
    {err_count, checks_done} = '0;
    rst_i = 1'b1;
    pins = $urandom(41492);
    repeat (16) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    // Reset values, last slot unmapped
    for (int k = 0; k < 6; k++) begin
      bus(1'b0, ra[k], 32'h0);
      chk(q, {24'h0, rv[k]});
    end
    bus(1'b1, SAC_ADDR_PIN1, {24'h0, pins[7:0]});
    bus(1'b1, SAC_ADDR_PIN2, {24'h0, pins[15:8]});
    bus(1'b0, SAC_ADDR_PIN2, 32'h0);
    chk(q, {24'h0, pins[15:8]});
    chk({16'h0, pin_analog_enable_o}, {16'h0, pins[15:0]});
    // Every channel code, each write aborting the last
    for (int ch = 0; ch < 32; ch++) begin
      bus(1'b1, SAC_ADDR_CTRL1, ch);
      chk({27'h0, mux_select_o}, ch);
      chk(mux_enable_o, exp_en(ch[4:0], pins[15:0]));
      chk({temp_sensor_route_o, bandgap_route_o, converter_power_o},
          {ch == SAC_CH_TEMP, ch == SAC_CH_BANDGAP, ch != SAC_CH_OFF});
    end
    // Sources, dividers, widths and compare; first two are corner inputs
    for (int i = 0; i < 12; i++) begin
      md = (i % 3 == 0) ? SAC_MODE_8 : (i % 3 == 1) ? SAC_MODE_10 : SAC_MODE_12;
      @(posedge clk_sys_i);
      analog <= (i < 2) ? {12{i[0]}} : 12'($urandom);
      wait_mode_i <= (i >= 8);
      bus(1'b1, SAC_ADDR_CONFIG, {25'h0, i[3:2], 1'b0, md, i[1:0]});
      cmp = fmt(12'($urandom), md);
      bus(1'b1, SAC_ADDR_COMPARE, cmp);
      bus(1'b1, SAC_ADDR_CTRL2, {26'h0, i >= 6, i[0], 4'h0});
      bus(1'b1, SAC_ADDR_CTRL1, 32'h40);
      idle(200, n);
      if (i[1:0] == 2'b00) tm[i[3:2]] = n;
      x = fmt(analog, md);
      f = (i < 6) || (i[0] ? (x >= cmp) : (x < cmp));
      if (f) r = x;
      chk(irq_o, f);
      bus(1'b0, SAC_ADDR_RESULT, 32'h0);
      chk(q, r);
      bus(1'b0, SAC_ADDR_CTRL1, 32'h0);
      chk(q[SAC_C1_COMPLETE], 1'b0);
    end
    chk(tm[2] > tm[0], 1'b1);
    // Continuous run, then the off code stops it
    bus(1'b1, SAC_ADDR_CONFIG, 32'h0);
    bus(1'b1, SAC_ADDR_CTRL2, 32'h0);
    bus(1'b1, SAC_ADDR_CTRL1, 32'h60);
    wait_irq(100);
    bus(1'b0, SAC_ADDR_RESULT, 32'h0);
    wait_irq(100);
    bus(1'b1, SAC_ADDR_CTRL1, 32'h1F);
    repeat (40) @(negedge clk_sys_i);
    bus(1'b0, SAC_ADDR_CTRL2, 32'h0);
    chk({q[SAC_C2_ACTIVE], converter_power_o}, 2'b00);
    // Stop3 on the local clock, conversion still completes
    @(posedge clk_sys_i);
    stop3_mode_i <= 1'b1;
    bus(1'b1, SAC_ADDR_CONFIG, 32'h3);
    bus(1'b1, SAC_ADDR_CTRL1, 32'h0);
    idle(200, n);
    // Counter match as the only start, held counter gives none
    bus(1'b1, SAC_ADDR_CTRL2, 32'h40);
    bus(1'b1, SAC_ADDR_CTRL1, 32'h40);
    repeat (100) @(negedge clk_sys_i);
    chk(irq_o, 1'b0);
    @(posedge clk_sys_i);
    run <= 1'b1;
    wait_irq(400);
    end_sim();
  end
endmodule
